// File: src/charge_port_power_mgmt.sv
// charge port power manager: modes, load status, auto switch, faults, apb
//
// Function
// RULE1: charging modes advertise charging, use high limit
// RULE2: system moves extra ports to low-limit sdp
// RULE3: sdp port returns to charging on pin change
// RULE4: 1110 to 1111 enters cdp without discharge
// RULE5: load status is indicator; high limit stays
// RULE6: assert status after 200ms above threshold
// RULE7: release status after 3s below threshold
// RULE8: cdp misread as dcp: discharge, become sdp
// RULE9: phone connected as sdp: back to cdp
// RULE10: shorted output at start gives constant current
// RULE11: overload shuts down only via thermal limit
// RULE12: fault held low while condition lasts
// RULE13: limit fault deglitched, thermal fault immediate
// RULE14: thermal off above 170, back after cooling
// RULE15: undervoltage lockout holds switch off, hysteretic
// RULE16: low limit open only without load management
// RULE17: synced comparator flags, ms time base
// RULE18: 1111 cdp high limit, 1110 sdp low
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module charge_port_power_mgmt #(
	parameter int unsigned TICK_CYCLES = charge_port_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire charge_port_pkg::apb_req_t apb_req,
	output charge_port_pkg::apb_rsp_t apb_rsp,
	input wire charge_port_pkg::pins_t pins,
	input wire charge_port_pkg::sense_t sense,
	output logic switch_on,
	output logic high_limit_setting,
	output logic advertise_charge,
	output logic vbus_discharge,
	output logic port_sdp,
	output logic cc_mode,
	output logic load_status_oe_n,
	output logic fault_oe_n,
	output logic irq
);
	import charge_port_pkg::*;

	localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);

	ctrl_state_t q;
	ctrl_state_t d;
	logic assert_done;
	logic release_done;
	logic glitch_done;
	logic disch_done;
	logic charging;
	logic stat_on;
	logic access;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;

	// pins to mode: 1111 cdp, 1110 sdp_no_discharge_mode, ctl3 low sdp1, other auto charging
	function automatic mode_t decode_mode(input pins_t p);
		if (!p.charge_mode_pins[0])
			return M_SDP1;
		else if (p.charge_mode_pins == 3'h7)
			return p.limit_select ? M_CDP : M_SDP_NO_DISCHARGE_MODE;
		else
			return M_DCP;
	endfunction : decode_mode

	assign charging = (q.mode == M_CDP) || (q.mode == M_DCP);
	assign stat_on = !q.stat_n;
	assign access = apb_req.psel && apb_req.penable && q.rsp.pready;

	// qualifiers on the ms time base
	qual_timer #(.CNT_W(CNT_W), .LIMIT(ASSERT_TICKS)) u_assert (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(q.tick),
		.run(charging && q.s2.load_above && !stat_on),
		.done(assert_done)
	);
	qual_timer #(.CNT_W(CNT_W), .LIMIT(RELEASE_TICKS)) u_release (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(q.tick),
		.run(charging && q.s2.load_below && stat_on),
		.done(release_done)
	);
	qual_timer #(.CNT_W(CNT_W), .LIMIT(DEGLITCH_TICKS)) u_glitch (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(q.tick),
		.run(q.s2.in_limit && q.switch_on),
		.done(glitch_done)
	);
	qual_timer #(.CNT_W(CNT_W), .LIMIT(DISCH_TICKS)) u_disch (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(q.tick),
		.run(q.as == AS_DISCH),
		.done(disch_done)
	);

	// next-state logic of the whole block
	always_comb
	begin
		d = q;
		ev = '0;
		clr = '0;
		// RULE17 two-stage sync
		d.p1 = pins;
		d.p2 = q.p1;
		d.s1 = sense;
		d.s2 = q.s1;
		// free-running ms time base
		d.tick = (q.pre == TICK_LAST);
		d.pre = d.tick ? '0 : q.pre + PRE_W'(1);
		// RULE3 mode follows pins
		d.mode = decode_mode(q.p2);
		// RULE14 thermal hysteresis
		if (q.s2.temp_hot)
			d.thermal_off = 1'b1;
		else if (q.s2.temp_cooled)
			d.thermal_off = 1'b0;
		// RULE15 lockout hysteresis
		if (q.s2.vin_above_on)
			d.input_undervoltage_lockout_ok = 1'b1;
		else if (q.s2.vin_below_off)
			d.input_undervoltage_lockout_ok = 1'b0;
		// RULE6 RULE7 load status qualify
		if (!charging)
			d.stat_n = 1'b1;
		else if (!stat_on && assert_done)
			d.stat_n = 1'b0;
		else if (stat_on && release_done)
			d.stat_n = 1'b1;
		// RULE12 RULE13 fault level
		d.fault_n = !(q.s2.temp_hot || q.thermal_off || glitch_done);
		// RULE8 RULE9 auto switch sequence
		unique case (q.as)
			AS_CDP:
				if (q.mode == M_CDP && q.ctrl[CTRL_AUTOSW_BIT]
					&& q.s2.phone_dcp_nodata)
					d.as = AS_DISCH;
			AS_DISCH:
				if (disch_done)
					d.as = AS_SDP;
			AS_SDP:
				if (q.s2.phone_sdp_conn || q.mode != M_CDP)
				begin
					d.as = AS_CDP;
					ev[EV_AUTOSW] = 1'b1;
				end
			default:
				d.as = AS_CDP;
		endcase
		// RULE11 only thermal, lockout, the ctrl enable bit or the auto switch discharge opens the switch
		d.switch_on = q.ctrl[CTRL_ENABLE_BIT] && q.input_undervoltage_lockout_ok
			&& !q.thermal_off && q.as != AS_DISCH;
		// RULE4 discharge only from the auto switch
		d.discharge = (q.as == AS_DISCH);
		// RULE1 RULE5 RULE18 limit and advertisement
		d.high_limit = (q.mode == M_SDP_NO_DISCHARGE_MODE) ? 1'b0
			: (q.mode == M_SDP1) ? q.p2.limit_select : 1'b1;
		d.advertise = charging && q.as == AS_CDP;
		// sdp shows once the discharge is over, not during it
		d.port_sdp = !charging || q.as == AS_SDP;
		// RULE10 constant current from the limit flag while the switch is on
		d.cc_mode = q.switch_on && q.s2.in_limit;
		// interrupt events
		ev[EV_STAT_ON] = q.stat_n && !d.stat_n;
		ev[EV_STAT_OFF] = !q.stat_n && d.stat_n;
		ev[EV_FAULT] = q.fault_n && !d.fault_n;
		ev[EV_THERM] = !q.thermal_off && d.thermal_off;
		// apb: answer in the access cycle after each setup
		d.rsp.pready = apb_req.psel && !apb_req.penable;
		if (apb_req.psel && !apb_req.penable)
		begin
			d.rsp.pslverr = 1'b0;
			d.rsp.prdata = '0;
			unique case (apb_req.paddr)
				REG_CTRL:
					d.rsp.prdata[1:0] = q.ctrl;
				REG_STATE:
				begin
					d.rsp.prdata[ST_SWITCH] = q.switch_on;
					d.rsp.prdata[ST_HILIM] = q.high_limit;
					d.rsp.prdata[ST_STATUS] = stat_on;
					d.rsp.prdata[ST_FAULT] = !q.fault_n;
					d.rsp.prdata[ST_THERM] = q.thermal_off;
					d.rsp.prdata[ST_INPUT_UNDERVOLTAGE_LOCKOUT] = q.input_undervoltage_lockout_ok;
					d.rsp.prdata[ST_MODE +: 2] = q.mode;
					d.rsp.prdata[ST_AS +: 2] = q.as;
					d.rsp.prdata[ST_CC] = q.cc_mode;
					d.rsp.prdata[ST_DISCH] = q.discharge;
				end
				REG_INT_STATUS:
					d.rsp.prdata[EV_W-1:0] = q.ists;
				REG_INT_CLEAR:
					d.rsp.prdata = '0;
				REG_INT_ENABLE:
					d.rsp.prdata[EV_W-1:0] = q.ien;
				default:
					d.rsp.pslverr = 1'b1;
			endcase
		end
		// register writes take effect at the access edge
		if (access && apb_req.pwrite)
		begin
			if (apb_req.paddr == REG_CTRL)
				d.ctrl = apb_req.pwdata[1:0];
			if (apb_req.paddr == REG_INT_ENABLE)
				d.ien = apb_req.pwdata[EV_W-1:0];
			if (apb_req.paddr == REG_INT_CLEAR)
				clr = apb_req.pwdata[EV_W-1:0];
		end
		// sticky status: a new event beats its clear
		d.ists = (q.ists & ~clr) | ev;
		d.irq = |(d.ists & d.ien);
	end

	// state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.ien <= IEN_RST;
			q.stat_n <= 1'b1;
			q.fault_n <= 1'b1;
		end
		else if (ce)
			q <= d;
	end

	// outputs straight from the state register
	assign apb_rsp = q.rsp;
	assign switch_on = q.switch_on;
	assign high_limit_setting = q.high_limit;
	assign advertise_charge = q.advertise;
	assign vbus_discharge = q.discharge;
	assign port_sdp = q.port_sdp;
	assign cc_mode = q.cc_mode;
	assign load_status_oe_n = q.stat_n;
	assign fault_oe_n = q.fault_n;
	assign irq = q.irq;

	a_hot_opens_switch: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && q.s2.temp_hot) ##1 ce |=> !q.switch_on) // RULE14
		else $error("switch stayed on while hot");
	a_hot_fault_now: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && q.s2.temp_hot) |=> !q.fault_n) // RULE13
		else $error("thermal fault not immediate");
	a_fault_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && (q.thermal_off || glitch_done)) |=> !q.fault_n) // RULE12
		else $error("fault released while condition present");
	a_input_undervoltage_lockout_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !q.input_undervoltage_lockout_ok) |=> !q.switch_on) // RULE15
		else $error("switch on under lockout");
	a_sdp_no_discharge_mode_low: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && q.mode == M_SDP_NO_DISCHARGE_MODE) |=> !q.high_limit && q.port_sdp) // RULE18
		else $error("sdp_no_discharge_mode not at low limit");
	a_charge_high: assert property (@(posedge pclk) // RULE1
		disable iff (!presetn)
		(ce && charging && q.as == AS_CDP) |=> q.high_limit && q.advertise)
		else $error("charging mode lacks high limit");
	a_sdp_no_discharge_mode_cdp_nodisch: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && $past(q.mode) == M_SDP_NO_DISCHARGE_MODE && q.mode == M_CDP
			&& q.as == AS_CDP) |-> ##1 !q.discharge ##1 !q.discharge) // RULE4
		else $error("discharge on sdp_no_discharge_mode to cdp");
	a_status_timed: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(q.stat_n) |-> $past(assert_done) && $past(charging)) // RULE6
		else $error("load status asserted without interval");
	a_release_timed: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(q.stat_n) |-> $past(release_done) || !$past(charging)) // RULE7
		else $error("load status released early");
	a_sdp_nodisch: assert property (@(posedge pclk) disable iff (!presetn)
		(q.as == AS_SDP) |=> !q.discharge || q.as == AS_DISCH) // RULE9
		else $error("discharge while returning to cdp");
	a_cc_follows: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && q.switch_on && q.s2.in_limit) |=> q.cc_mode) // RULE10
		else $error("no constant current on limit");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> (q.irq == |(q.ists & q.ien)))
		else $error("interrupt not matching enabled status");
endmodule : charge_port_power_mgmt
`default_nettype wire

// File: src/charge_port_pkg.sv
// shared constants and types for the charge port power manager
package charge_port_pkg;
	// clock and internal time base
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned PRE_W = 15;
	localparam int unsigned CNT_W = 12;
	// qualification intervals in ms
	localparam int unsigned ASSERT_MS = 200;
	localparam int unsigned RELEASE_MS = 3000;
	localparam int unsigned DEGLITCH_MS = 8;
	localparam int unsigned DISCH_MS = 100;
	// the same intervals in time-base ticks
	localparam logic [CNT_W-1:0] ASSERT_TICKS = CNT_W'(ASSERT_MS * 1000 / TICK_US);
	localparam logic [CNT_W-1:0] RELEASE_TICKS = CNT_W'(RELEASE_MS * 1000 / TICK_US);
	localparam logic [CNT_W-1:0] DEGLITCH_TICKS =
		CNT_W'(DEGLITCH_MS * 1000 / TICK_US);
	localparam logic [CNT_W-1:0] DISCH_TICKS = CNT_W'(DISCH_MS * 1000 / TICK_US);
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_INT_STATUS = 8'h08;
	localparam logic [7:0] REG_INT_CLEAR = 8'h0c;
	localparam logic [7:0] REG_INT_ENABLE = 8'h10;
	// control register fields and reset value
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_AUTOSW_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;
	// state register fields
	localparam int unsigned ST_SWITCH = 0;
	localparam int unsigned ST_HILIM = 1;
	localparam int unsigned ST_STATUS = 2;
	localparam int unsigned ST_FAULT = 3;
	localparam int unsigned ST_THERM = 4;
	localparam int unsigned ST_INPUT_UNDERVOLTAGE_LOCKOUT = 5;
	localparam int unsigned ST_MODE = 6;
	localparam int unsigned ST_AS = 8;
	localparam int unsigned ST_CC = 10;
	localparam int unsigned ST_DISCH = 11;
	// event bits of the interrupt registers
	localparam int unsigned EV_W = 5;
	localparam int unsigned EV_STAT_ON = 0;
	localparam int unsigned EV_STAT_OFF = 1;
	localparam int unsigned EV_FAULT = 2;
	localparam int unsigned EV_THERM = 3;
	localparam int unsigned EV_AUTOSW = 4;
	localparam logic [EV_W-1:0] IEN_RST = 5'h00;

	typedef enum logic [1:0] {
		M_SDP1 = 2'b00,
		M_SDP_NO_DISCHARGE_MODE = 2'b01,
		M_CDP = 2'b10,
		M_DCP = 2'b11
	} mode_t;

	typedef enum logic [1:0] {
		AS_CDP = 2'b00,
		AS_DISCH = 2'b01,
		AS_SDP = 2'b10
	} as_t;

	typedef struct packed {
		logic [2:0] charge_mode_pins;
		logic limit_select;
	} pins_t;

	typedef struct packed {
		logic load_above;
		logic load_below;
		logic in_limit;
		logic temp_hot;
		logic temp_cooled;
		logic vin_above_on;
		logic vin_below_off;
		logic phone_dcp_nodata;
		logic phone_sdp_conn;
	} sense_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		pins_t p1;
		pins_t p2;
		sense_t s1;
		sense_t s2;
		logic [PRE_W-1:0] pre;
		logic tick;
		mode_t mode;
		as_t as;
		logic [1:0] ctrl;
		logic thermal_off;
		logic input_undervoltage_lockout_ok;
		logic stat_n;
		logic fault_n;
		logic switch_on;
		logic high_limit;
		logic advertise;
		logic discharge;
		logic port_sdp;
		logic cc_mode;
		logic [EV_W-1:0] ists;
		logic [EV_W-1:0] ien;
		logic irq;
		apb_rsp_t rsp;
	} ctrl_state_t;
endpackage : charge_port_pkg

// File: src/qual_timer.sv
// interval qualifier counting time-base ticks while its condition holds
`timescale 1ns/1ps
`default_nettype none
module qual_timer #(
	parameter int unsigned CNT_W = 12,
	parameter logic [CNT_W-1:0] LIMIT = CNT_W'(200)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic run,
	output logic done
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic done;
	} tstate_t;

	tstate_t q;
	tstate_t d;

	// any break in run restarts; LIMIT+1 ticks guarantee the least time
	always_comb
	begin
		d = q;
		if (!run)
		begin
			d.cnt = '0;
			d.done = 1'b0;
		end
		else if (tick && !q.done)
		begin
			if (q.cnt == LIMIT)
				d.done = 1'b1;
			else
				d.cnt = q.cnt + CNT_W'(1);
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign done = q.done;

	a_done_needs_run: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(q.done) |-> $past(run) && $past(tick)) // RULE17
		else $error("qualifier done without a running tick");
	a_break_restarts: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !run) |=> !q.done && q.cnt == '0) // RULE7
		else $error("qualifier kept its count after a break");
endmodule : qual_timer
`default_nettype wire

// File: sim/port_device_model.sv
// reactive model of the attached phone and load on the port
`timescale 1ns/1ps
`default_nettype none
module port_device_model (
	input wire logic pclk,
	input wire charge_port_pkg::sense_t base,
	input wire logic [1:0] load,
	input wire logic phone,
	input wire logic advertise_charge,
	input wire logic port_sdp,
	output charge_port_pkg::sense_t sense
);
	import charge_port_pkg::*;
	logic sdp_seen_q;
	sense_t sense_d;
	// comparator flags and phone reactions; phone takes a cdp port for dcp
	// until it has once seen sdp
	always_comb
	begin
		sense_d = base;
		sense_d.load_above = (load == 2'h2);
		sense_d.load_below = (load == 2'h0);
		sense_d.phone_dcp_nodata = phone & advertise_charge & !port_sdp
			& !sdp_seen_q;
		sense_d.phone_sdp_conn = phone & port_sdp;
	end
	// one assignment per signal, just after each edge
	always_ff @(posedge pclk)
	begin
		sense <= sense_d;
		sdp_seen_q <= phone & (sdp_seen_q | port_sdp);
	end
endmodule : port_device_model
`default_nettype wire

// File: sim/charge_port_power_mgmt_test.sv
// self-checking bench for the charge port power manager
`timescale 1ns/1ps
`default_nettype none
module charge_port_power_mgmt_test;
	import charge_port_pkg::*;
	logic pclk;
	logic presetn;
	logic ce;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	pins_t pins;
	sense_t base;
	sense_t sense;
	logic [1:0] load;
	logic phone;
	logic switch_on, high_limit_setting, advertise_charge, vbus_discharge;
	logic port_sdp, cc_mode, load_status_oe_n, fault_oe_n, irq;
	int mismatches;
	int n_checks;
	logic [31:0] rd;
	logic err;

	charge_port_power_mgmt #(.TICK_CYCLES(4)) u_dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .pins(pins), .sense(sense),
		.switch_on(switch_on), .high_limit_setting(high_limit_setting),
		.advertise_charge(advertise_charge), .vbus_discharge(vbus_discharge),
		.port_sdp(port_sdp), .cc_mode(cc_mode),
		.load_status_oe_n(load_status_oe_n), .fault_oe_n(fault_oe_n),
		.irq(irq)
	);

	port_device_model u_model (
		.pclk(pclk), .base(base), .load(load), .phone(phone),
		.advertise_charge(advertise_charge), .port_sdp(port_sdp),
		.sense(sense)
	);

	// 20 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	// one apb transfer; read data and error land in rd and err
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		chk("pready", 32'(apb_rsp.pready), 32'h1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge pclk);
	endtask : apb

	task conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// reset values, register access and an unmapped address
	task t_reset;
		wt(10);
		chk("switch in reset", 32'(switch_on), 32'h0);
		chk("status in reset", 32'(load_status_oe_n), 32'h1);
		chk("fault in reset", 32'(fault_oe_n), 32'h1);
		presetn <= 1'b1;
		wt(10);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl reset", rd, 32'h3);
		chk("mapped err", 32'(err), 32'h0);
		apb(1'b0, REG_INT_ENABLE, 32'h0);
		chk("enable reset", rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, REG_STATE, 32'h0);
		apb(1'b0, REG_STATE, 32'h0);
		chk("switch on", 32'(rd[ST_SWITCH]), 32'h1);
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl write", rd, 32'h0);
		apb(1'b1, REG_CTRL, 32'h3);
	endtask : t_reset

	// one pin code per mode: sdp1, sdp_no_discharge_mode, cdp, dcp
	task t_modes;
		logic [3:0] code [4];
		code = '{4'hd, 4'he, 4'hf, 4'h2};
		for (int i = 0; i < 4; i++)
		begin
			pins <= code[i];
			wt(10);
			apb(1'b0, REG_STATE, 32'h0);
			chk("mode", 32'(rd[7:6]), 32'(i));
			chk("advertise", 32'(advertise_charge), 32'(i > 1));
			if (i > 0)
				chk("high limit", 32'(high_limit_setting), 32'(i > 1));
		end
	endtask : t_modes

	// sdp_no_discharge_mode back to cdp with no discharge
	task t_sdp_no_discharge_mode;
		logic seen;
		pins <= 4'he;
		wt(10);
		chk("sdp_no_discharge_mode limit", 32'(high_limit_setting), 32'h0);
		chk("sdp_no_discharge_mode advertise", 32'(advertise_charge), 32'h0);
		pins.limit_select <= 1'b1;
		seen = 1'b0;
		repeat (12)
		begin
			@(posedge pclk);
			seen |= vbus_discharge | !switch_on;
		end
		chk("no discharge", 32'(seen), 32'h0);
		chk("cdp advertise", 32'(advertise_charge), 32'h1);
		chk("cdp limit", 32'(high_limit_setting), 32'h1);
	endtask : t_sdp_no_discharge_mode

	// load status timing and its interrupt
	task t_load;
		apb(1'b1, REG_INT_CLEAR, 32'h1f);
		load <= 2'h2;
		wt(795);
		chk("status early", 32'(load_status_oe_n), 32'h1);
		wt(35);
		chk("status set", 32'(load_status_oe_n), 32'h0);
		chk("limit kept", 32'(high_limit_setting), 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b0, REG_INT_STATUS, 32'h0);
		chk("event", 32'(rd[EV_STAT_ON]), 32'h1);
		apb(1'b1, REG_INT_ENABLE, 32'h1);
		wt(2);
		chk("irq on", 32'(irq), 32'h1);
		apb(1'b1, REG_INT_CLEAR, 32'h1);
		wt(2);
		chk("irq off", 32'(irq), 32'h0);
		apb(1'b1, REG_INT_ENABLE, 32'h0);
		load <= 2'h0;
		wt(2000);
		load <= 2'h1;
		wt(10);
		load <= 2'h0;
		wt(11990);
		chk("status held", 32'(load_status_oe_n), 32'h0);
		wt(40);
		chk("status free", 32'(load_status_oe_n), 32'h1);
	endtask : t_load

	// phone misreads cdp, port goes sdp then back to cdp
	task t_auto;
		int n;
		logic seen;
		phone <= 1'b1;
		n = 0;
		while (vbus_discharge !== 1'b1 && n < 30)
		begin
			wt(1);
			n++;
		end
		chk("discharge", 32'(vbus_discharge), 32'h1);
		chk("switch off", 32'(switch_on), 32'h0);
		n = 0;
		while (port_sdp !== 1'b1 && n < 500)
		begin
			wt(1);
			n++;
		end
		chk("sdp reached", 32'(n >= 400 && n < 500), 32'h1);
		seen = 1'b0;
		repeat (12)
		begin
			@(posedge pclk);
			seen |= vbus_discharge;
		end
		chk("no 2nd discharge", 32'(seen), 32'h0);
		chk("sdp left", 32'(port_sdp), 32'h0);
		chk("cdp again", 32'(advertise_charge), 32'h1);
		phone <= 1'b0;
	endtask : t_auto

	// limit fault deglitch, thermal cut and restart
	task t_fault;
		base.in_limit <= 1'b1;
		wt(10);
		chk("cc mode", 32'(cc_mode), 32'h1);
		chk("still on", 32'(switch_on), 32'h1);
		chk("deglitch", 32'(fault_oe_n), 32'h1);
		wt(40);
		chk("limit fault", 32'(fault_oe_n), 32'h0);
		base.in_limit <= 1'b0;
		wt(10);
		chk("fault gone", 32'(fault_oe_n), 32'h1);
		base.temp_hot <= 1'b1;
		wt(5);
		chk("hot fault", 32'(fault_oe_n), 32'h0);
		wt(2);
		chk("hot off", 32'(switch_on), 32'h0);
		base.temp_hot <= 1'b0;
		wt(10);
		chk("not cooled", 32'(switch_on), 32'h0);
		chk("fault held", 32'(fault_oe_n), 32'h0);
		base.temp_cooled <= 1'b1;
		wt(10);
		chk("restart", 32'(switch_on), 32'h1);
		chk("fault clear", 32'(fault_oe_n), 32'h1);
		base.temp_cooled <= 1'b0;
	endtask : t_fault

	// lockout with hysteresis, start into a short
	task t_input_undervoltage_lockout;
		base.in_limit <= 1'b1;
		base.vin_above_on <= 1'b0;
		base.vin_below_off <= 1'b1;
		wt(10);
		chk("lockout", 32'(switch_on), 32'h0);
		base.vin_below_off <= 1'b0;
		wt(10);
		chk("hysteresis", 32'(switch_on), 32'h0);
		base.vin_above_on <= 1'b1;
		wt(10);
		chk("power up", 32'(switch_on), 32'h1);
		chk("short start", 32'(cc_mode), 32'h1);
		base.in_limit <= 1'b0;
	endtask : t_input_undervoltage_lockout

	// main sequence
	initial
	begin
		presetn = 1'b0;
		ce = 1'b1;
		apb_req = '0;
		pins = 4'hf;
		base = '0;
		base.vin_above_on = 1'b1;
		load = 2'h0;
		phone = 1'b0;
		mismatches = 0;
		n_checks = 0;
		t_reset();
		t_modes();
		t_sdp_no_discharge_mode();
		t_load();
		t_auto();
		t_fault();
		t_input_undervoltage_lockout();
		conclude();
	end

	// hang guard, well beyond the longest run
	initial
	begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		conclude();
	end
endmodule : charge_port_power_mgmt_test
`default_nettype wire
